// *** hdl/psb_map.svh ***
`ifndef PSB_MAP_SVH
`define PSB_MAP_SVH
// ----------------------------------------
// Bus addresses and limits
// ----------------------------------------
`define PSB_ADDR_CMD 8'h20
`define PSB_ADDR_EEP 8'hA0
`define PSB_ADDR_MASK 8'hFE
`define PSB_BLK_MAX 8'hFF
`define PSB_BITS 4'h8
`define PSB_EEP_AW 11
`define PSB_EEP_WORDS 2048
// ----------------------------------------
// Times and derived cycle counts
// ----------------------------------------
`define PSB_CLK_NS 20
`define PSB_STRETCH_MS 1
`define PSB_TMO_MS 25
`define PSB_WRT_MS 5
`define PSB_QTR_NS 2500
`define PSB_STRETCH_CYC (`PSB_STRETCH_MS * 1000000 / `PSB_CLK_NS)
`define PSB_TMO_CYC ((`PSB_TMO_MS * 1000000 + `PSB_CLK_NS - 1) / `PSB_CLK_NS)
`define PSB_WRT_CYC ((`PSB_WRT_MS * 1000000 + `PSB_CLK_NS - 1) / `PSB_CLK_NS)
`define PSB_QTR_CYC ((`PSB_QTR_NS + `PSB_CLK_NS - 1) / `PSB_CLK_NS)
`endif

// *** hdl/psb_pkg.sv ***
`default_nettype none
package psb_pkg;
   typedef enum logic [1:0] {SEL_NONE, SEL_CMD, SEL_EEP} psb_sel_t;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RXACK, ST_WAIT, ST_TX, ST_TXACK} psb_tgt_st_t;
   typedef enum logic [1:0] {OP_START = 2'h0, OP_STOP = 2'h1, OP_WRITE = 2'h2,
      OP_READ = 2'h3} psb_op_t;
endpackage
`default_nettype wire

// *** hdl/psb_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface psb_if;
   logic scl_h_o;
   logic scl_h_oe;
   logic sda_h_o;
   logic sda_h_oe;
   logic scl_t_o;
   logic scl_t_oe;
   logic sda_t_o;
   logic sda_t_oe;
   logic scl;
   logic sda;
   logic wp_protect;
   logic attention_flag_out;
   // ----------------------------------------
   // Open-drain wired-AND with pull-up
   // ----------------------------------------
   assign scl = ~((scl_h_oe & ~scl_h_o) | (scl_t_oe & ~scl_t_o));
   assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_t_oe & ~sda_t_o));
   modport tgt (input scl, input sda, input wp_protect, output scl_t_o, output scl_t_oe,
      output sda_t_o, output sda_t_oe, output attention_flag_out);
   modport host (input scl, input sda, input attention_flag_out, output scl_h_o,
      output scl_h_oe, output sda_h_o, output sda_h_oe, output wp_protect);
endinterface
`default_nettype wire

// *** hdl/psb_target.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "psb_map.svh"
module psb_target #(
   parameter int STRETCH_CYC = `PSB_STRETCH_CYC,
   parameter int TMO_CYC = `PSB_TMO_CYC,
   parameter int WRT_CYC = `PSB_WRT_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Shared bus
   psb_if.tgt bus,
   // Command target user side
   output logic [7:0] cmd_code,
   output logic cmd_strobe,
   output logic [7:0] wr_data,
   output logic wr_strobe,
   output logic rd_req,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   output logic xfer_end,
   // Events
   input wire logic shutdown_evt,
   input wire logic warning_evt
);
   logic [1:0] scl_m;
   logic [1:0] sda_m;
   logic [1:0] wp_m;
   logic scl_p;
   logic sda_p;
   logic scl_s;
   logic sda_s;
   logic rise;
   logic fall;
   logic start_c;
   logic stop_c;
   logic [20:0] tmo_q;
   logic tmo_hit;
   logic [17:0] bsy_q;
   logic [15:0] str_q;
   logic [7:0] mem [0:`PSB_EEP_WORDS-1];
   logic [`PSB_EEP_AW-1:0] ptr_q;
   logic mem_we_q;
   logic [`PSB_EEP_AW-1:0] mem_wa_q;
   logic [7:0] mem_wd_q;
   psb_pkg::psb_tgt_st_t st_q;
   psb_pkg::psb_sel_t sel_q;
   logic [7:0] sh_q;
   logic [3:0] bit_q;
   logic addr_q;
   logic rd_q;
   logic nack_q;
   logic wrote_q;
   logic [7:0] nb_q;
   logic [7:0] adr;
   logic have;
   logic [7:0] dat;

   // ----------------------------------------
   // Pin synchronisers and bus conditions
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         scl_m <= 2'h3;
         sda_m <= 2'h3;
         wp_m <= 2'h3;
         scl_p <= 1'h1;
         sda_p <= 1'h1;
      end else begin
         scl_m <= {scl_m[0], bus.scl};
         sda_m <= {sda_m[0], bus.sda};
         wp_m <= {wp_m[0], bus.wp_protect};
         scl_p <= scl_m[1];
         sda_p <= sda_m[1];
      end
   end
   assign scl_s = scl_m[1];
   assign sda_s = sda_m[1];
   assign rise = scl_s & ~scl_p;
   assign fall = ~scl_s & scl_p;
   assign start_c = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_c = scl_s & scl_p & ~sda_p & sda_s;
   assign adr = sh_q & `PSB_ADDR_MASK;

   // ----------------------------------------
   // SCL low timeout
   // ----------------------------------------
   assign tmo_hit = (tmo_q == 21'(TMO_CYC));
   always_ff @(posedge sys_clk) begin
      if (!nrst || scl_s) begin
         tmo_q <= 21'h0;
      end else if (!tmo_hit) begin
         tmo_q <= tmo_q + 21'h1;
      end
   end

   // ----------------------------------------
   // EEPROM programming busy time
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         bsy_q <= 18'h0;
      end else if (stop_c && wrote_q) begin
         bsy_q <= 18'(WRT_CYC);
      end else if (bsy_q != 18'h0) begin
         bsy_q <= bsy_q - 18'h1;
      end
   end

   // ----------------------------------------
   // User storage, written only by the byte engine from bus data bytes
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (mem_we_q) begin
         mem[mem_wa_q] <= mem_wd_q;
      end
   end

   // ----------------------------------------
   // Read data source for the next byte
   // ----------------------------------------
   always_comb begin
      have = 1'h0;
      dat = 8'hFF;
      if (sel_q == psb_pkg::SEL_EEP) begin
         have = 1'h1;
         dat = mem[ptr_q];
      end else if (rd_valid) begin
         have = 1'h1;
         dat = rd_data;
      end else if (str_q == 16'(STRETCH_CYC - 1)) begin
         have = 1'h1;
      end
   end

   // ----------------------------------------
   // Alert output
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         bus.attention_flag_out <= 1'h0;
      end else begin
         bus.attention_flag_out <= shutdown_evt | warning_evt;
      end
   end

   // ----------------------------------------
   // Byte engine
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st_q <= psb_pkg::ST_IDLE;
         sel_q <= psb_pkg::SEL_NONE;
         bus.sda_t_o <= 1'h0;
         bus.scl_t_o <= 1'h0;
         bus.sda_t_oe <= 1'h0;
         bus.scl_t_oe <= 1'h0;
         sh_q <= 8'h0;
         bit_q <= 4'h0;
         addr_q <= 1'h0;
         rd_q <= 1'h0;
         nack_q <= 1'h0;
         wrote_q <= 1'h0;
         nb_q <= 8'h0;
         ptr_q <= '0;
         str_q <= 16'h0;
         cmd_code <= 8'h0;
         wr_data <= 8'h0;
         cmd_strobe <= 1'h0;
         wr_strobe <= 1'h0;
         rd_req <= 1'h0;
         xfer_end <= 1'h0;
         mem_we_q <= 1'h0;
         mem_wa_q <= '0;
         mem_wd_q <= 8'h0;
      end else begin
         cmd_strobe <= 1'h0;
         wr_strobe <= 1'h0;
         rd_req <= 1'h0;
         xfer_end <= 1'h0;
         mem_we_q <= 1'h0;
         if (tmo_hit) begin
            st_q <= psb_pkg::ST_IDLE;
            sel_q <= psb_pkg::SEL_NONE;
            bus.sda_t_oe <= 1'h0;
            bus.scl_t_oe <= 1'h0;
         end else if (start_c) begin
            st_q <= psb_pkg::ST_RX;
            addr_q <= 1'h1;
            bit_q <= 4'h0;
            wrote_q <= 1'h0;
            bus.sda_t_oe <= 1'h0;
         end else if (stop_c) begin
            st_q <= psb_pkg::ST_IDLE;
            sel_q <= psb_pkg::SEL_NONE;
            xfer_end <= (sel_q == psb_pkg::SEL_CMD);
            bus.sda_t_oe <= 1'h0;
         end else begin
            case (st_q)
               psb_pkg::ST_RX: begin
                  if (rise) begin
                     sh_q <= {sh_q[6:0], sda_s};
                     bit_q <= bit_q + 4'h1;
                  end else if (fall && bit_q == `PSB_BITS) begin
                     st_q <= psb_pkg::ST_RXACK;
                     if (addr_q) begin
                        addr_q <= 1'h0;
                        rd_q <= sh_q[0];
                        nb_q <= 8'h0;
                        if (adr == `PSB_ADDR_CMD) begin
                           sel_q <= psb_pkg::SEL_CMD;
                           bus.sda_t_oe <= 1'h1;
                        end else if (adr == `PSB_ADDR_EEP && bsy_q == 18'h0) begin
                           sel_q <= psb_pkg::SEL_EEP;
                           bus.sda_t_oe <= 1'h1;
                        end else begin
                           sel_q <= psb_pkg::SEL_NONE;
                           st_q <= psb_pkg::ST_IDLE;
                        end
                     end else begin
                        bus.sda_t_oe <= (nb_q != `PSB_BLK_MAX);
                        if (nb_q != `PSB_BLK_MAX) begin
                           nb_q <= nb_q + 8'h1;
                        end
                        if (sel_q == psb_pkg::SEL_CMD && nb_q == 8'h0) begin
                           cmd_code <= sh_q;
                           cmd_strobe <= 1'h1;
                        end else if (sel_q == psb_pkg::SEL_CMD) begin
                           wr_data <= sh_q;
                           wr_strobe <= nb_q != `PSB_BLK_MAX;
                        end else if (nb_q == 8'h0) begin
                           ptr_q <= {ptr_q[`PSB_EEP_AW-1:8], sh_q};
                        end else begin
                           ptr_q <= ptr_q + 1'h1;
                           mem_wa_q <= ptr_q;
                           mem_wd_q <= sh_q;
                           mem_we_q <= ~wp_m[1];
                           wrote_q <= wrote_q | ~wp_m[1];
                        end
                     end
                  end
               end
               psb_pkg::ST_RXACK: begin
                  if (fall) begin
                     bus.sda_t_oe <= 1'h0;
                     bit_q <= 4'h0;
                     if (rd_q) begin
                        st_q <= psb_pkg::ST_WAIT;
                        bus.scl_t_oe <= 1'h1;
                        rd_req <= (sel_q == psb_pkg::SEL_CMD);
                        str_q <= 16'h0;
                     end else begin
                        st_q <= psb_pkg::ST_RX;
                     end
                  end
               end
               psb_pkg::ST_WAIT: begin
                  str_q <= str_q + 16'h1;
                  if (have) begin
                     sh_q <= dat;
                     bus.sda_t_oe <= ~dat[7];
                     bus.scl_t_oe <= 1'h0;
                     bit_q <= 4'h1;
                     st_q <= psb_pkg::ST_TX;
                     if (nb_q != `PSB_BLK_MAX) begin
                        nb_q <= nb_q + 8'h1;
                     end
                     if (sel_q == psb_pkg::SEL_EEP) begin
                        ptr_q <= ptr_q + 1'h1;
                     end
                  end
               end
               psb_pkg::ST_TX: begin
                  if (fall && bit_q == `PSB_BITS) begin
                     bus.sda_t_oe <= 1'h0;
                     st_q <= psb_pkg::ST_TXACK;
                  end else if (fall) begin
                     bus.sda_t_oe <= ~sh_q[6];
                     sh_q <= {sh_q[6:0], 1'h0};
                     bit_q <= bit_q + 4'h1;
                  end
               end
               psb_pkg::ST_TXACK: begin
                  if (rise) begin
                     nack_q <= sda_s;
                  end else if (fall && (nack_q || nb_q == `PSB_BLK_MAX)) begin
                     st_q <= psb_pkg::ST_IDLE;
                  end else if (fall) begin
                     st_q <= psb_pkg::ST_WAIT;
                     bus.scl_t_oe <= 1'h1;
                     rd_req <= (sel_q == psb_pkg::SEL_CMD);
                     str_q <= 16'h0;
                  end
               end
               default: begin
                  // Pins stay released, only a start leaves here
                  bus.sda_t_oe <= 1'h0;
                  bus.scl_t_oe <= 1'h0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** hdl/psb_host.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "psb_map.svh"
module psb_host #(
   parameter int WRT_CYC = `PSB_WRT_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Shared bus
   psb_if.host bus,
   // Byte operation port
   input wire logic op_valid,
   input wire psb_pkg::psb_op_t op_code,
   input wire logic [7:0] op_wdata,
   input wire logic op_nack,
   output logic op_ready,
   output logic op_done,
   output logic [7:0] op_rdata,
   output logic op_acked,
   // Write protect control
   input wire logic wp_unprotect
);
   logic [1:0] scl_m;
   logic [1:0] sda_m;
   logic [6:0] qc_q;
   logic tick;
   logic run_q;
   psb_pkg::psb_op_t op_q;
   logic nack_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [17:0] grd_q;
   logic [1:0] nw_q;
   logic eep_q;
   logic arm_q;
   logic bit_op;

   assign tick = (qc_q == 7'(`PSB_QTR_CYC - 1));
   assign bit_op = (op_q == psb_pkg::OP_WRITE) || (op_q == psb_pkg::OP_READ);

   // ----------------------------------------
   // Pin synchronisers, quarter-bit divider
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         scl_m <= 2'h3;
         sda_m <= 2'h3;
         qc_q <= 7'h0;
         bus.wp_protect <= 1'h1;
      end else begin
         scl_m <= {scl_m[0], bus.scl};
         sda_m <= {sda_m[0], bus.sda};
         qc_q <= tick ? 7'h0 : qc_q + 7'h1;
         bus.wp_protect <= ~wp_unprotect;
      end
   end

   // ----------------------------------------
   // Post-write guard before a new start
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         grd_q <= 18'h0;
      end else if (op_done && op_q == psb_pkg::OP_STOP && arm_q) begin
         grd_q <= 18'(WRT_CYC);
      end else if (grd_q != 18'h0) begin
         grd_q <= grd_q - 18'h1;
      end
   end

   // ----------------------------------------
   // Bit sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         run_q <= 1'h0;
         op_q <= psb_pkg::OP_STOP;
         nack_q <= 1'h0;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h0;
         nw_q <= 2'h0;
         eep_q <= 1'h0;
         arm_q <= 1'h0;
         op_ready <= 1'h0;
         op_done <= 1'h0;
         op_rdata <= 8'h0;
         op_acked <= 1'h0;
         bus.scl_h_o <= 1'h0;
         bus.sda_h_o <= 1'h0;
         bus.scl_h_oe <= 1'h0;
         bus.sda_h_oe <= 1'h0;
      end else begin
         op_done <= 1'h0;
         // Done cycle blocks ready until a fresh guard is visible
         op_ready <= ~run_q && ~op_valid && ~op_done && grd_q == 18'h0;
         if (!run_q) begin
            if (op_valid && op_ready) begin
               // Caller sequences single-byte EEPROM accesses
               run_q <= 1'h1;
               op_ready <= 1'h0;
               op_q <= op_code;
               nack_q <= op_nack;
               sh_q <= op_wdata;
               ph_q <= 2'h0;
               bit_q <= 4'h0;
            end
         end else if (tick && (ph_q != 2'h2 || scl_m[1])) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
               2'h0: begin
                  if (op_q == psb_pkg::OP_START) begin
                     bus.sda_h_oe <= 1'h0;
                  end else if (op_q == psb_pkg::OP_STOP) begin
                     bus.sda_h_oe <= 1'h1;
                  end else if (bit_q == `PSB_BITS) begin
                     bus.sda_h_oe <= (op_q == psb_pkg::OP_READ) && !nack_q;
                  end else begin
                     bus.sda_h_oe <= (op_q == psb_pkg::OP_WRITE) && !sh_q[7];
                  end
               end
               2'h1: begin
                  bus.scl_h_oe <= 1'h0;
               end
               2'h2: begin
                  if (op_q == psb_pkg::OP_START) begin
                     bus.sda_h_oe <= 1'h1;
                  end else if (op_q == psb_pkg::OP_STOP) begin
                     bus.sda_h_oe <= 1'h0;
                  end else if (bit_q == `PSB_BITS) begin
                     op_acked <= ~sda_m[1];
                  end else begin
                     sh_q <= {sh_q[6:0], sda_m[1]};
                  end
               end
               default: begin
                  bus.scl_h_oe <= (op_q != psb_pkg::OP_STOP);
                  bit_q <= bit_q + 4'h1;
                  if (!bit_op || bit_q == `PSB_BITS) begin
                     run_q <= 1'h0;
                     op_done <= 1'h1;
                     op_rdata <= sh_q;
                     bus.sda_h_oe <= 1'h0;
                  end
                  if (op_q == psb_pkg::OP_START) begin
                     // Armed until the next start so the stop can load the guard
                     nw_q <= 2'h0;
                     arm_q <= 1'h0;
                  end else if (op_q == psb_pkg::OP_WRITE && bit_q == `PSB_BITS) begin
                     if (nw_q == 2'h0) begin
                        eep_q <= (sh_q == `PSB_ADDR_EEP);
                     end else if (nw_q == 2'h2 && eep_q) begin
                        arm_q <= 1'h1;
                     end
                     if (nw_q != 2'h3) begin
                        nw_q <= nw_q + 2'h1;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** bench/psb_link_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module psb_link_sva #(
   parameter int STRETCH_CYC = 200,
   parameter int TMO_CYC = 2000
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Bus wires and drives
   input wire logic scl,
   input wire logic scl_h_o,
   input wire logic sda_h_o,
   input wire logic scl_t_o,
   input wire logic scl_t_oe,
   input wire logic sda_t_o,
   input wire logic sda_t_oe,
   // Alert and its causes
   input wire logic attention_flag_out,
   input wire logic shutdown_evt,
   input wire logic warning_evt
);
   int str_n;
   int low_n;
   // ------
   // Run lengths of stretch and of low clock
   // ------
   always_ff @(posedge sys_clk) begin
      if (!nrst || !scl_t_oe) begin
         str_n <= 0;
      end else begin
         str_n <= str_n + 1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!nrst || scl) begin
         low_n <= 0;
      end else begin
         low_n <= low_n + 1;
      end
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   alert_set_a: assert property (shutdown_evt || warning_evt |=> attention_flag_out)
      else $error("alert not raised");
   alert_clr_a: assert property (!(shutdown_evt || warning_evt) |=> !attention_flag_out)
      else $error("alert not cleared");
   stretch_max_a: assert property (str_n <= STRETCH_CYC + 2)
      else $error("clock held too long");
   timeout_rel_a: assert property (low_n > TMO_CYC + 6 |-> !scl_t_oe && !sda_t_oe)
      else $error("bus kept after timeout");
   sda_quiet_a: assert property (!$stable(sda_t_oe) |-> !$past(scl))
      else $error("data moved while clock high");
   stretch_low_a: assert property ($rose(scl_t_oe) |-> !$past(scl))
      else $error("clock pulled while high");
   tgt_od_a: assert property (!scl_t_o && !sda_t_o)
      else $error("target drives high");
   host_od_a: assert property (!scl_h_o && !sda_h_o)
      else $error("host drives high");
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int STR = 200;
   localparam int TMO = 2000;
   localparam int WRT = 500;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic op_valid = 1'b0;
   psb_pkg::psb_op_t op_code = psb_pkg::OP_START;
   logic [7:0] op_wdata = 8'h00;
   logic op_nack = 1'b0;
   logic op_ready, op_done, op_acked, cmd_strobe, wr_strobe, rd_req, xfer_end;
   logic [7:0] op_rdata, cmd_code, wr_data, rdat, last_code;
   logic [7:0] rd_data = 8'h00;
   logic rd_valid = 1'b0;
   logic shutdown_evt = 1'b0;
   logic warning_evt = 1'b0;
   logic wp_unprotect = 1'b0;
   logic ack;
   logic [15:0] wr_sh = 16'h0000;
   logic [7:0] rsp_q[$];
   int cmd_n = 0;
   int wr_n = 0;
   int end_n = 0;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int waited;
   always #10 sys_clk = ~sys_clk;
   psb_if bus();
   psb_target #(.STRETCH_CYC(STR), .TMO_CYC(TMO), .WRT_CYC(WRT)) u_psb_target (
      .sys_clk(sys_clk), .nrst(nrst), .bus(bus), .cmd_code(cmd_code),
      .cmd_strobe(cmd_strobe), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_req(rd_req),
      .rd_data(rd_data), .rd_valid(rd_valid), .xfer_end(xfer_end),
      .shutdown_evt(shutdown_evt), .warning_evt(warning_evt));
   psb_host #(.WRT_CYC(WRT)) u_psb_host (
      .sys_clk(sys_clk), .nrst(nrst), .bus(bus), .op_valid(op_valid), .op_code(op_code),
      .op_wdata(op_wdata), .op_nack(op_nack), .op_ready(op_ready), .op_done(op_done),
      .op_rdata(op_rdata), .op_acked(op_acked), .wp_unprotect(wp_unprotect));
   psb_link_sva #(.STRETCH_CYC(STR), .TMO_CYC(TMO)) u_psb_link_sva (
      .sys_clk(sys_clk), .nrst(nrst), .scl(bus.scl), .scl_h_o(bus.scl_h_o),
      .sda_h_o(bus.sda_h_o), .scl_t_o(bus.scl_t_o), .scl_t_oe(bus.scl_t_oe),
      .sda_t_o(bus.sda_t_o), .sda_t_oe(bus.sda_t_oe),
      .attention_flag_out(bus.attention_flag_out), .shutdown_evt(shutdown_evt),
      .warning_evt(warning_evt));
   // ------
   // User side watch, read responder, hang guard
   // ------
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cmd_strobe === 1'b1) begin
         cmd_n <= cmd_n + 1;
         last_code <= cmd_code;
      end
      if (wr_strobe === 1'b1) begin
         wr_n <= wr_n + 1;
         wr_sh <= {wr_sh[7:0], wr_data};
      end
      if (xfer_end === 1'b1) begin
         end_n <= end_n + 1;
      end
      if (cyc == 160000) begin
         errors = errors + 1;
         give_verdict();
      end
   end
   always begin
      @(posedge sys_clk);
      if (rd_req === 1'b1 && rsp_q.size() > 0) begin
         repeat (20) @(posedge sys_clk);
         rd_data <= rsp_q.pop_front();
         rd_valid <= 1'b1;
         @(posedge sys_clk);
         rd_valid <= 1'b0;
      end
   end
   // ------
   // Shared tasks
   // ------
   task automatic give_verdict;
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic op(input psb_pkg::psb_op_t c, input logic [7:0] d, input logic nk);
      waited = 0;
      @(negedge sys_clk);
      while (op_ready !== 1'b1) begin
         waited = waited + 1;
         @(negedge sys_clk);
      end
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_wdata <= d;
      op_nack <= nk;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      @(negedge sys_clk);
      while (op_done !== 1'b1) @(negedge sys_clk);
      rdat = op_rdata;
      ack = op_acked;
   endtask
   task automatic st;
      op(psb_pkg::OP_START, 8'h00, 1'b0);
   endtask
   task automatic sp;
      op(psb_pkg::OP_STOP, 8'h00, 1'b0);
   endtask
   task automatic wr(input logic [7:0] d, input logic a);
      op(psb_pkg::OP_WRITE, d, 1'b0);
      chk({15'h0000, ack}, {15'h0000, a});
   endtask
   // ------
   // Scenarios
   // ------
   task automatic t_alert;
      for (int i = 0; i < 5; i++) begin
         @(posedge sys_clk);
         {shutdown_evt, warning_evt} <= 2'(i);
         repeat (3) @(negedge sys_clk);
         chk({15'h0000, bus.attention_flag_out}, {15'h0000, (i % 4) != 0});
      end
      $display("test alert done");
   endtask
   task automatic t_nack;
      st();
      wr(8'h42, 1'b0);
      st();
      wr(8'h20, 1'b1);
      wr(8'hC1, 1'b1);
      sp();
      chk({8'h00, last_code}, 16'h00C1);
      chk(16'(cmd_n), 16'h0001);
      chk(16'(wr_n), 16'h0000);
      $display("test nack done");
   endtask
   task automatic t_tmo;
      int c0;
      c0 = cmd_n;
      st();
      wr(8'h20, 1'b1);
      repeat (TMO + 20) @(negedge sys_clk);
      wr(8'hC2, 1'b0);
      sp();
      chk(16'(cmd_n - c0), 16'h0000);
      $display("test timeout done");
   endtask
   task automatic t_cmd_wr;
      int e0;
      int w0;
      e0 = end_n;
      w0 = wr_n;
      st();
      wr(8'h20, 1'b1);
      wr(8'hB7, 1'b1);
      wr(8'h5A, 1'b1);
      wr(8'hA5, 1'b1);
      sp();
      chk({8'h00, last_code}, 16'h00B7);
      chk(wr_sh, 16'h5AA5);
      chk(16'(wr_n - w0), 16'h0002);
      chk(16'(end_n - e0), 16'h0001);
      $display("test command write done");
   endtask
   task automatic t_cmd_rd;
      rsp_q.push_back(8'h3C);
      st();
      wr(8'h20, 1'b1);
      wr(8'h8B, 1'b1);
      st();
      wr(8'h21, 1'b1);
      op(psb_pkg::OP_READ, 8'h00, 1'b0);
      chk({8'h00, rdat}, 16'h003C);
      op(psb_pkg::OP_READ, 8'h00, 1'b1);
      chk({8'h00, rdat}, 16'h00FF);
      sp();
      chk({8'h00, last_code}, 16'h008B);
      $display("test command read done");
   endtask
   task automatic t_eep;
      int c0;
      c0 = cmd_n;
      @(posedge sys_clk);
      wp_unprotect <= 1'b1;
      st();
      wr(8'hA0, 1'b1);
      wr(8'h35, 1'b1);
      wr(8'hC3, 1'b1);
      sp();
      @(posedge sys_clk);
      wp_unprotect <= 1'b0;
      st();
      chk(16'(waited >= WRT), 16'h0001);
      wr(8'hA0, 1'b1);
      wr(8'h35, 1'b1);
      wr(8'h3C, 1'b1);
      sp();
      st();
      wr(8'hA0, 1'b1);
      wr(8'h35, 1'b1);
      st();
      wr(8'hA1, 1'b1);
      op(psb_pkg::OP_READ, 8'h00, 1'b1);
      chk({8'h00, rdat}, 16'h00C3);
      sp();
      chk(16'(cmd_n - c0), 16'h0000);
      $display("test eeprom done");
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      t_alert();
      t_nack();
      t_tmo();
      t_cmd_wr();
      t_cmd_rd();
      t_eep();
      give_verdict();
   end
endmodule
`default_nettype wire
